// >>> cg_clock_gen.sv
/*
 * Clock generator mode-switching logic: AXI4-Lite control and status
 * registers, reference and bus dividers, loop enables and a glitch-free
 * output source multiplexer. All clocks are seen as sampled levels on
 * aclk, which must run well above every reference and loop clock.
 * Assumes the oscillator, FLL and PLL report readiness and lock as
 * levels synchronous to aclk.
 */
// What this block does
// - External reference, source select 00, FLL selected: FLL drives output.
// - External reference, source select 10: external clock drives output directly.
// - FLL bypassed external mode keeps FLL running and reporting lock.
// - Oscillator-ready flag sets after crystal init; software waits for it.
// - Source select 01 switches output to internal reference; software waits status.
// - Each select change appears later in its status bit; software checks.
// - Bus clock is generated clock divided by two in every mode.
// - Internal FLL mode: divided internal reference times 1024 over bus divider.
// - External FLL mode: divided external reference times 1024 over bus divider.
// - Bypass modes: selected reference divided only by bus divider.
// - External PLL mode: divided reference times multiplier over bus divider.
// - Control 2 holds bus divider, range, gain, crystal, output enable.
// - Control 1 holds source select, reference divider, reference select.
// - Status holds internal reference status bit 4, source status 3:2.
// - Control 3 holds loop select bit 6, multiplier bits 3:0.
// - Low-power external bypass keeps both loops off; writes only prepare.
// - Low-power bit enters or leaves low-power bypass per loop select.
// - Loop select status sets when PLL active; lock flag when PLL locks.
// - Loop select set and source 00: PLL drives output, status 11.
// - Unavailable new source leaves previous source driving output.
// - Bus divider writes take effect immediately, no handshake.
`timescale 1ns/100ps
`default_nettype none
module cg_clock_gen (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock levels from the references and loops.
   input wire logic ext_ref_in,
   input wire logic int_ref_in,
   input wire logic fll_clk_in,
   input wire logic pll_clk_in,
   // Status from the oscillator and loops.
   input wire logic osc_stable_in,
   input wire logic fll_lock_in,
   input wire logic pll_lock_in,
   // Controls to the oscillator and loops.
   output logic osc_enable,
   output logic osc_high_range,
   output logic osc_high_gain,
   output logic osc_crystal,
   output logic fll_enable,
   output logic pll_enable,
   output logic [3:0] vco_mult_out,
   output logic ref_div_clk_out,
   // Generated clocks and mode.
   output logic gen_clock_out,
   output logic bus_clock_out,
   output logic ext_ref_out,
   output logic int_ref_out,
   output logic [7:0] mode_out
);
   import cg_pkg::*;

   // Tap of a ripple-style edge counter: divide by 2**sel, sel 0 passes raw.
   function automatic logic div_tap(input logic [6:0] cnt, input logic [2:0] sel,
                                    input logic raw);
      logic r;
      r = raw;
      if (sel != 3'h0) begin
         r = cnt[sel - 3'h1];
      end
      return r;
   endfunction

   // Level of one of the four output sources.
   function automatic logic src_level(input logic [1:0] sel, input logic f,
                                      input logic i, input logic e, input logic p);
      logic r;
      unique case (sel)
         SRC_FLL: r = f;
         SRC_INT: r = i;
         SRC_EXT: r = e;
         SRC_PLL: r = p;
      endcase
      return r;
   endfunction

   logic [7:0] clkgen_ctrl1_reg;
   logic [7:0] clkgen_ctrl2_reg;
   logic [7:0] clkgen_ctrl3_reg;
   logic [1:0] clk_source_status;
   logic int_ref_status;
   logic pll_select_status;
   logic osc_ready_flag;
   logic lock_flag;
   cg_sw_state_t sw_state;
   logic [6:0] ref_cnt;
   logic [6:0] bus_cnt;
   logic ref_prev;
   logic src_prev;
   logic [7:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;

   // Register fields by their working names.
   wire logic [1:0] clk_source_sel = clkgen_ctrl1_reg[C1_CLK_SOURCE_SEL_LSB +: 2];
   wire logic [2:0] ref_divider_sel = clkgen_ctrl1_reg[C1_REF_DIVIDER_SEL_LSB +: 3];
   wire logic int_ref_select = clkgen_ctrl1_reg[C1_INT_REF_SELECT_BIT];
   wire logic int_ref_out_en = clkgen_ctrl1_reg[C1_INT_REF_OUT_EN_BIT];
   wire logic [1:0] bus_divider_sel = clkgen_ctrl2_reg[C2_BUS_DIVIDER_SEL_LSB +: 2];
   wire logic high_gain_osc = clkgen_ctrl2_reg[C2_HGO_BIT];
   wire logic low_power_bypass = clkgen_ctrl2_reg[C2_LP_BIT];
   wire logic ext_crystal_sel = clkgen_ctrl2_reg[C2_XTAL_BIT];
   wire logic ext_ref_out_en = clkgen_ctrl2_reg[C2_EXT_REF_OUT_EN_BIT];
   wire logic pll_select = clkgen_ctrl3_reg[C3_PLL_SELECT_BIT];
   wire logic [3:0] vco_multiplier_sel = clkgen_ctrl3_reg[C3_VCO_MULTIPLIER_SEL_LSB +: 4];
   wire logic [7:0] clkgen_status_reg = {1'b0, lock_flag, pll_select_status,
      int_ref_status, clk_source_status, osc_ready_flag, 1'b0};
   // Low power applies only while a bypass source drives the output.
   wire logic lp_active = low_power_bypass
      && (clk_source_status == SRC_INT || clk_source_status == SRC_EXT);
   wire logic ext_avail = !ext_crystal_sel || osc_ready_flag;
   wire logic next_fll_en = !lp_active && !pll_select_status;
   wire logic next_pll_en = !lp_active && pll_select_status;

   // Source that the select asks for; select 00 means the active loop.
   wire logic [1:0] src_target = (clk_source_sel == SRC_FLL)
      ? (pll_select_status ? SRC_PLL : SRC_FLL) : clk_source_sel;
   wire logic tgt_avail = (src_target == SRC_INT)
      || (src_target == SRC_EXT && ext_avail)
      || (src_target == SRC_FLL && fll_enable)
      || (src_target == SRC_PLL && pll_enable && lock_flag);
   wire logic tgt_valid = (clk_source_sel != SRC_PLL);
   wire logic old_lvl = src_level(clk_source_status, fll_clk_in, int_ref_in,
                                  ext_ref_in, pll_clk_in);
   wire logic new_lvl = src_level(src_target, fll_clk_in, int_ref_in,
                                  ext_ref_in, pll_clk_in);
   wire logic need_switch = tgt_valid && tgt_avail && src_target != clk_source_status;
   wire logic switch_ok = sw_state == SW_ARM && need_switch && !new_lvl;
   // The output is held low while the switch is armed, so no runt pulse escapes.
   wire logic mux_lvl = (sw_state == SW_ARM) ? 1'b0 : old_lvl;
   // Loop reference: the selected reference through the reference divider.
   wire logic ref_src = int_ref_status ? int_ref_in : ext_ref_in;
   wire logic ref_rise = ref_src && !ref_prev;
   wire logic src_rise = mux_lvl && !src_prev;
   wire logic next_ref_div = div_tap(ref_cnt, ref_divider_sel, ref_src);
   wire logic next_gen = div_tap(bus_cnt, {1'b0, bus_divider_sel}, mux_lvl);
   wire logic int_ref_select_ok = !int_ref_in && !ext_ref_in && (int_ref_select || ext_avail);
   // Operating mode as seen from the status.
   wire logic [7:0] next_mode = (clk_source_status == SRC_PLL) ? MODE_PEE
      : (clk_source_status == SRC_FLL) ? (int_ref_status ? MODE_FEI : MODE_FEE)
      : (clk_source_status == SRC_INT) ? (lp_active ? MODE_LOWPOWER_INT_BYPASS_MODE : MODE_FBI)
      : lp_active ? MODE_LOWPOWER_EXT_BYPASS_MODE : (pll_select_status ? MODE_PBE : MODE_FBE);
   // Bus decode.
   wire logic do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire logic w_hit = waddr == OFS_CTRL1 || waddr == OFS_CTRL2
      || waddr == OFS_CTRL3 || waddr == OFS_STATUS;
   wire logic w_lane = do_write && wstrb[0];
   wire logic r_hit = s_axi_araddr == OFS_CTRL1 || s_axi_araddr == OFS_CTRL2
      || s_axi_araddr == OFS_CTRL3 || s_axi_araddr == OFS_STATUS;
   wire logic [7:0] r_byte = (s_axi_araddr == OFS_CTRL1) ? clkgen_ctrl1_reg
      : (s_axi_araddr == OFS_CTRL2) ? clkgen_ctrl2_reg
      : (s_axi_araddr == OFS_CTRL3) ? clkgen_ctrl3_reg
      : (s_axi_araddr == OFS_STATUS) ? clkgen_status_reg : 8'h00;

   // Write address and data are taken in either order and held until the response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         waddr <= 8'h00;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            waddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata <= s_axi_wdata;
            wstrb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Control registers; only byte lane 0 carries data, status is read-only.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clkgen_ctrl1_reg <= RST_CTRL1;
         clkgen_ctrl2_reg <= RST_CTRL2;
         clkgen_ctrl3_reg <= RST_CTRL3;
      end else if (w_lane) begin
         if (waddr == OFS_CTRL1) begin
            clkgen_ctrl1_reg <= wdata[7:0];
         end
         if (waddr == OFS_CTRL2) begin
            clkgen_ctrl2_reg <= wdata[7:0];
         end
         if (waddr == OFS_CTRL3) begin
            clkgen_ctrl3_reg <= wdata[7:0] & C3_WMASK;
         end
      end
   end

   // Reads answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, r_byte};
         s_axi_rresp <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Status bits follow their selects once the hardware has really moved.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_ref_status <= 1'b1;
         pll_select_status <= 1'b0;
         osc_ready_flag <= 1'b0;
         lock_flag <= 1'b0;
      end else begin
         // Reference change waits until both references are low.
         if (int_ref_status != int_ref_select && int_ref_select_ok) begin
            int_ref_status <= int_ref_select;
         end
         // Loop choice is frozen in low power, so writes there only prepare.
         if (!lp_active) begin
            pll_select_status <= pll_select;
         end
         osc_ready_flag <= ext_crystal_sel && osc_stable_in;
         lock_flag <= pll_select_status ? (pll_enable && pll_lock_in)
                                        : (fll_enable && fll_lock_in);
      end
   end

   // Glitch-free switch: wait for the old source low, gate, wait for the new low.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_state <= SW_RUN;
         clk_source_status <= SRC_FLL;
      end else begin
         unique case (sw_state)
            SW_RUN: begin
               if (need_switch) begin
                  sw_state <= SW_DRAIN;
               end
            end
            SW_DRAIN: begin
               if (!need_switch) begin
                  sw_state <= SW_RUN;
               end else if (!old_lvl) begin
                  sw_state <= SW_ARM;
               end
            end
            SW_ARM: begin
               if (!need_switch) begin
                  sw_state <= SW_RUN;
               end else if (!new_lvl) begin
                  clk_source_status <= src_target;
                  sw_state <= SW_RUN;
               end
            end
            default: sw_state <= SW_RUN;
         endcase
      end
   end

   // Reference and bus dividers count rising edges of their sampled inputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_prev <= 1'b0;
         src_prev <= 1'b0;
         ref_cnt <= 7'h00;
         bus_cnt <= 7'h00;
      end else begin
         ref_prev <= ref_src;
         src_prev <= mux_lvl;
         ref_cnt <= ref_cnt + {6'h00, ref_rise};
         bus_cnt <= bus_cnt + {6'h00, src_rise};
      end
   end

   // Registered outputs; the loop multiplies the divided reference itself.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_clock_out <= 1'b0;
         bus_clock_out <= 1'b0;
         ref_div_clk_out <= 1'b0;
         fll_enable <= 1'b1;
         pll_enable <= 1'b0;
         mode_out <= MODE_FEI;
      end else begin
         gen_clock_out <= next_gen;
         bus_clock_out <= bus_clock_out ^ (next_gen && !gen_clock_out);
         ref_div_clk_out <= next_ref_div;
         fll_enable <= next_fll_en;
         pll_enable <= next_pll_en;
         mode_out <= next_mode;
      end
   end

   // Oscillator controls and reference clock outputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_enable <= 1'b0;
         osc_high_range <= 1'b0;
         osc_high_gain <= 1'b0;
         osc_crystal <= 1'b0;
         vco_mult_out <= 4'h0;
         ext_ref_out <= 1'b0;
         int_ref_out <= 1'b0;
      end else begin
         osc_enable <= ext_ref_out_en || !int_ref_status;
         osc_high_range <= clkgen_ctrl2_reg[C2_RANGE_BIT];
         osc_high_gain <= high_gain_osc;
         osc_crystal <= ext_crystal_sel;
         vco_mult_out <= vco_multiplier_sel;
         ext_ref_out <= ext_ref_out_en && ext_ref_in;
         int_ref_out <= int_ref_out_en && int_ref_in;
      end
   end

   chk_bus_half_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(bus_clock_out) == $rose(gen_clock_out))
      else $error("bus clock did not follow generated clock rise");
   chk_lp_loops_off: assert property (@(posedge aclk) disable iff (!aresetn)
      lp_active |=> !fll_enable && !pll_enable)
      else $error("loop enabled in low power bypass");
   chk_pll_status_src: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_source_status == SRC_PLL |-> pll_select_status)
      else $error("pll source shown without pll selected");
   chk_switch_safe: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(clk_source_status) |-> $past(switch_ok) && !$past(mux_lvl))
      else $error("source switched while a clock was high");
   chk_hold_unavail: assert property (@(posedge aclk) disable iff (!aresetn)
      !tgt_avail |=> $stable(clk_source_status))
      else $error("switched to an unavailable source");
   chk_ref_div_pass: assert property (@(posedge aclk) disable iff (!aresetn)
      ref_divider_sel == 3'h0 |=> ref_div_clk_out == $past(ref_src))
      else $error("reference divider 1 not passing reference");
   chk_osc_ready: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 osc_ready_flag == $past(ext_crystal_sel && osc_stable_in))
      else $error("oscillator ready flag wrong");
   chk_fbe_fll_on: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_out == MODE_FBE |-> fll_enable)
      else $error("fll off in fll bypassed external mode");
   chk_bus_divider_sel_now: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_divider_sel == 2'h0 |=> gen_clock_out == $past(mux_lvl))
      else $error("bus divider 1 not immediate");
endmodule
`default_nettype wire

// >>> cg_pkg.sv
/*
 * Shared constants of the clock generator mode-switching block: register
 * offsets, field positions, reset values, source codes and mode codes.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
`default_nettype none
package cg_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_CTRL3 = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // Control register 1 fields.
   localparam int C1_CLK_SOURCE_SEL_LSB = 6;
   localparam int C1_REF_DIVIDER_SEL_LSB = 3;
   localparam int C1_INT_REF_SELECT_BIT = 2;
   localparam int C1_INT_REF_OUT_EN_BIT = 1;
   // Control register 2 fields.
   localparam int C2_BUS_DIVIDER_SEL_LSB = 6;
   localparam int C2_RANGE_BIT = 5;
   localparam int C2_HGO_BIT = 4;
   localparam int C2_LP_BIT = 3;
   localparam int C2_XTAL_BIT = 2;
   localparam int C2_EXT_REF_OUT_EN_BIT = 1;
   // Control register 3 fields.
   localparam int C3_PLL_SELECT_BIT = 6;
   localparam int C3_VCO_MULTIPLIER_SEL_LSB = 0;
   localparam logic [7:0] C3_WMASK = 8'h4F;
   // Status register fields.
   localparam int ST_LOCK_BIT = 6;
   localparam int ST_PLL_SELECT_STATUS_BIT = 5;
   localparam int ST_IREFST_BIT = 4;
   localparam int ST_CLK_SOURCE_STATUS_LSB = 2;
   localparam int ST_OSC_READY_FLAG_BIT = 1;

   // Reset values: internal FLL mode, bus divider at divide-by-2.
   localparam logic [7:0] RST_CTRL1 = 8'h04;
   localparam logic [7:0] RST_CTRL2 = 8'h40;
   localparam logic [7:0] RST_CTRL3 = 8'h01;

   // Clock source codes shared by the select and status fields.
   localparam logic [1:0] SRC_FLL = 2'h0;
   localparam logic [1:0] SRC_INT = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;
   localparam logic [1:0] SRC_PLL = 2'h3;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operating modes, one-hot.
   localparam logic [7:0] MODE_FEI = 8'h01;
   localparam logic [7:0] MODE_FEE = 8'h02;
   localparam logic [7:0] MODE_FBE = 8'h04;
   localparam logic [7:0] MODE_FBI = 8'h08;
   localparam logic [7:0] MODE_PEE = 8'h10;
   localparam logic [7:0] MODE_PBE = 8'h20;
   localparam logic [7:0] MODE_LOWPOWER_INT_BYPASS_MODE = 8'h40;
   localparam logic [7:0] MODE_LOWPOWER_EXT_BYPASS_MODE = 8'h80;

   // States of the glitch-free source switch.
   typedef enum logic [2:0] {
      SW_RUN = 3'b001,
      SW_DRAIN = 3'b010,
      SW_ARM = 3'b100
   } cg_sw_state_t;

endpackage
`default_nettype wire

// >>> cg_ref_model.sv
/* Model of the crystal, internal reference and both loops beside the block.
   Assumes it shares aclk and aresetn with the block. */
`timescale 1ns/100ps
`default_nettype none
module cg_ref_model #(
   parameter int OSC_DELAY = 60,
   parameter int LOCK_DELAY = 30
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Enables from the block.
   input wire logic osc_enable,
   input wire logic fll_enable,
   input wire logic pll_enable,
   // Levels to the block.
   output logic ext_ref_in,
   output logic int_ref_in,
   output logic fll_clk_in,
   output logic pll_clk_in,
   output logic osc_stable_in,
   output logic fll_lock_in,
   output logic pll_lock_in
);
   logic [7:0] tick;
   int osc_cnt;
   int fll_cnt;
   int pll_cnt;
   // A stopped source parks low, so a stale level never passes for a clock.
   assign ext_ref_in = osc_enable & tick[3];
   assign int_ref_in = tick[4];
   assign fll_clk_in = fll_enable & tick[2];
   assign pll_clk_in = pll_enable & tick[1];
   assign osc_stable_in = osc_cnt >= OSC_DELAY;
   assign fll_lock_in = fll_cnt >= LOCK_DELAY;
   assign pll_lock_in = pll_cnt >= LOCK_DELAY;
   // Start-up and lock times restart whenever the part is switched off.
   always_ff @(posedge aclk) begin
      tick <= aresetn ? tick + 8'h01 : 8'h00;
      osc_cnt <= (aresetn && osc_enable) ? osc_cnt + 1 : 0;
      fll_cnt <= (aresetn && fll_enable) ? fll_cnt + 1 : 0;
      pll_cnt <= (aresetn && pll_enable) ? pll_cnt + 1 : 0;
   end
endmodule
`default_nettype wire

// >>> tb_top.sv
/* Self-checking bench: walks the block from reset through the clock modes.
   Assumes the reference model stands at the far side. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cg_pkg::*;
   logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [7:0] awa, ara, mode_out;
   logic [31:0] wd, rdd, rd;
   logic [3:0] vco, ws;
   logic [1:0] bresp, rresp, resp;
   logic ext, intr, fllc, pllc, oscs, flll, plll, osce, flle, plle, gen, bus;
   logic orng, ogain, oxtal, ero;
   int fail_count = 0;
   int checks = 0;
   int gc = 0;
   int bc = 0;
   int ec = 0;
   cg_clock_gen dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_ref_in(ext),
      .int_ref_in(intr), .fll_clk_in(fllc), .pll_clk_in(pllc), .osc_stable_in(oscs),
      .fll_lock_in(flll), .pll_lock_in(plll), .osc_enable(osce), .osc_high_range(orng),
      .osc_high_gain(ogain), .osc_crystal(oxtal), .fll_enable(flle), .pll_enable(plle),
      .vco_mult_out(vco), .ref_div_clk_out(), .gen_clock_out(gen), .bus_clock_out(bus),
      .ext_ref_out(ero), .int_ref_out(), .mode_out(mode_out));
   cg_ref_model ref_u (.aclk(aclk), .aresetn(aresetn), .osc_enable(osce), .fll_enable(flle),
      .pll_enable(plle), .ext_ref_in(ext), .int_ref_in(intr), .fll_clk_in(fllc),
      .pll_clk_in(pllc), .osc_stable_in(oscs), .fll_lock_in(flll), .pll_lock_in(plll));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Edge counters on the generated clocks give the division ratios.
   always @(posedge gen) gc++;
   always @(posedge bus) bc++;
   always @(posedge ero) ec++;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Each channel is released only at the edge that takes it.
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awa <= a;
      awv <= 1'b1;
      wd <= {24'h000000, d};
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      resp = bresp;
      br <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rd = rdd;
      resp = rresp;
      rr <= 1'b0;
   endtask
   // Software polls status until the masked field settles; the watchdog bounds it.
   task automatic poll(input logic [31:0] m, input logic [31:0] e);
      do rd8(OFS_STATUS); while ((rd & m) != e);
      check(rd & m, e);
   endtask
   task t_reset;
      rd8(OFS_CTRL1);
      check(rd, {24'h000000, RST_CTRL1});
      rd8(OFS_CTRL2);
      check(rd, {24'h000000, RST_CTRL2});
      rd8(OFS_CTRL3);
      check(rd, {24'h000000, RST_CTRL3});
      wr8(OFS_STATUS, 8'hFF);
      rd8(OFS_STATUS);
      check(rd, 32'h00000010);
      rd8(8'h10);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      // A write with byte lane 0 off must leave the register alone.
      ws <= 4'h0;
      wr8(OFS_CTRL3, 8'h00);
      ws <= 4'hF;
      check({30'h0, resp}, {30'h0, RESP_OKAY});
      rd8(OFS_CTRL3);
      check(rd, {24'h000000, RST_CTRL3});
      check({24'h0, mode_out}, {24'h0, MODE_FEI});
   endtask
   task t_ext;
      wr8(OFS_CTRL1, 8'h44);
      poll(32'h0000001C, 32'h00000014);
      check({24'h0, mode_out}, {24'h0, MODE_FBI});
      wr8(OFS_CTRL2, 8'h36);
      wr8(OFS_CTRL1, 8'hB8);
      rd8(OFS_STATUS);
      check(rd & 32'h0000000E, 32'h00000004);
      check({29'h0, oxtal, ogain, orng}, 32'h00000007);
      poll(32'h00000002, 32'h00000002);
      poll(32'h0000001C, 32'h00000008);
      poll(32'h00000040, 32'h00000040);
      check({31'h0, flle}, 32'h00000001);
      check({24'h0, mode_out}, {24'h0, MODE_FBE});
   endtask
   task t_pll;
      wr8(OFS_CTRL2, 8'h3E);
      rd8(OFS_STATUS);
      check({24'h0, mode_out}, {24'h0, MODE_LOWPOWER_EXT_BYPASS_MODE});
      wr8(OFS_CTRL1, 8'h90);
      wr8(OFS_CTRL3, 8'h44);
      check({30'h0, flle, plle}, 32'h00000000);
      // The multiplier output trails the register by one edge.
      @(posedge aclk);
      check({28'h0, vco}, 32'h00000004);
      wr8(OFS_CTRL2, 8'h36);
      poll(32'h00000060, 32'h00000060);
      check({24'h0, mode_out}, {24'h0, MODE_PBE});
      wr8(OFS_CTRL1, 8'h10);
      poll(32'h0000000C, 32'h0000000C);
      check({24'h0, mode_out}, {24'h0, MODE_PEE});
   endtask
   // Ratios are judged within one edge, since the window cuts periods.
   task t_div;
      int g1;
      gc = 0;
      bc = 0;
      ec = 0;
      repeat (200) @(posedge aclk);
      g1 = gc;
      check(32'(ec inside {12, 13}), 32'h1);
      check(32'((bc - gc / 2) inside {-1, 0, 1}), 32'h1);
      wr8(OFS_CTRL2, 8'h76);
      gc = 0;
      repeat (200) @(posedge aclk);
      check(32'((gc - g1 / 2) inside {-1, 0, 1}), 32'h1);
   endtask
   // Back out of the loop modes: external FLL, then low-power internal bypass.
   task t_fee;
      wr8(OFS_CTRL1, 8'h90);
      poll(32'h0000000C, 32'h00000008);
      wr8(OFS_CTRL1, 8'hB8);
      wr8(OFS_CTRL3, 8'h04);
      poll(32'h00000060, 32'h00000040);
      wr8(OFS_CTRL1, 8'h38);
      poll(32'h0000001C, 32'h00000000);
      check({24'h0, mode_out}, {24'h0, MODE_FEE});
      wr8(OFS_CTRL1, 8'h44);
      poll(32'h0000001C, 32'h00000014);
      wr8(OFS_CTRL2, 8'h08);
      rd8(OFS_STATUS);
      check({24'h0, mode_out}, {24'h0, MODE_LOWPOWER_INT_BYPASS_MODE});
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      final_report();
   end
   initial begin
      {aresetn, awv, wv, br, arv, rr} = 6'h00;
      awa = 8'h00;
      ara = 8'h00;
      wd = 32'h00000000;
      ws = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_ext();
      t_pll();
      t_div();
      t_fee();
      final_report();
   end
endmodule
`default_nettype wire
